// >>> design/schp_pkg.sv
// Package of constants, types and helpers for the SCSI host port
package schp_pkg;

    // ------------------------------------------------------------
    // Widths and host address map
    // ------------------------------------------------------------
    localparam int DW = 8;
    localparam int AW = 4;
    localparam int NREG = 15;
    localparam int IDW = 3;
    localparam logic [AW-1:0] ADDR_THRU = 4'hF;
    localparam logic [AW-1:0] REG_CTRL = 4'h0;
    localparam logic [AW-1:0] REG_IRQ_MASK = 4'h1;
    localparam logic [AW-1:0] REG_IRQ_STAT = 4'h2;
    localparam logic [AW-1:0] REG_SCSI_OUT = 4'h3;
    localparam logic [AW-1:0] REG_SCSI_IN = 4'h4;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_ID_LSB = 0;
    localparam int CTRL_PCHK = 3;
    localparam int CTRL_PH_LSB = 4;
    localparam int PHW = 3;
    localparam int CTRL_PROG = 7;

    // ------------------------------------------------------------
    // Interrupt status bits
    // ------------------------------------------------------------
    localparam int IRQ_SRST = 0;
    localparam int IRQ_SPAR = 1;
    localparam int IRQ_WRDY = 2;
    localparam int IRQ_RDONE = 3;
    localparam int IRQ_HPAR = 4;

    // ------------------------------------------------------------
    // Bus phase codes in the control register
    // ------------------------------------------------------------
    localparam logic [PHW-1:0] PH_FREE = 3'h0;
    localparam logic [PHW-1:0] PH_ARB = 3'h1;
    localparam logic [PHW-1:0] PH_SEL = 3'h2;
    localparam logic [PHW-1:0] PH_OUT = 3'h3;
    localparam logic [PHW-1:0] PH_IN = 3'h4;
    localparam logic [DW-1:0] ZERO = 8'h00;

    typedef enum logic [2:0] {
        SCHP_FREE, SCHP_ARB, SCHP_SEL, SCHP_OUT, SCHP_IN
    } schp_phase_t;

    // Byte with its parity bit
    typedef struct packed {
        logic [DW-1:0] data;
        logic par;
    } schp_byte_t;

    // Driven byte: value plus active-low enable
    typedef struct packed {
        schp_byte_t val;
        logic oe_n;
    } schp_drv_t;

    // Whole state of the port
    typedef struct packed {
        logic [NREG-1:0][DW-1:0] regs;
        logic [DW-1:0] stat;
        logic rd_n;
        logic wr_n;
        schp_drv_t host;
        schp_drv_t dma;
        schp_byte_t sdo;
        schp_byte_t sde;
        logic irq;
    } schp_state_t;

    // Odd parity bit over a byte
    function automatic logic odd_par(input logic [DW-1:0] d);
        return ~(^d);
    endfunction : odd_par

endpackage : schp_pkg

// >>> design/schp_host_port.sv
// Host register port and SCSI data drive of a SCSI protocol controller
// Operation
// - Reset clears all state without clock
// - Strobes, address, data honoured only with select
// - Four address bits pick one register
// - Read gate drives addressed register out
// - Read strobe release ends program read
// - Write strobe release latches, except addresses 2, 4 and F
// - Write strobe release flags program data ready
// - Write-through copies host byte to DMA
// - Host bus floats except during reads
// - Eight bits plus odd parity
// - Interrupt holds until cause cleared
// - SCSI reset interrupt cannot be masked
// - SCSI input parity check is programmable
// - SCSI output byte with odd parity
// - Drive enable per data and parity bit
// - Free and inbound phases drive nothing
// - Arbitration drives only own ID bit
// - Selection and outbound drive all bits
`timescale 1ns/100ps
`default_nettype none

module schp_host_port (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // Host register port
    input wire logic cs_n_in,
    input wire logic [schp_pkg::AW-1:0] reg_addr_in,
    input wire logic read_strobe_n_in,
    input wire logic read_gate_n_in,
    input wire logic write_strobe_n_in,
    input wire logic write_through_gate_n_in,
    input wire logic [schp_pkg::DW-1:0] host_data_in,
    input wire logic host_parity_in,
    output logic [schp_pkg::DW-1:0] host_data_out,
    output logic host_parity_out,
    output logic host_data_oe_n_out,
    // DMA data bus
    input wire logic dma_dir_in,
    output logic [schp_pkg::DW-1:0] dma_data_out,
    output logic dma_parity_out,
    output logic dma_data_oe_n_out,
    // SCSI data bus
    input wire logic scsi_reset_in,
    input wire logic [schp_pkg::DW-1:0] scsi_data_in,
    input wire logic scsi_parity_in,
    output logic [schp_pkg::DW-1:0] scsi_data_out,
    output logic scsi_parity_out,
    output logic [schp_pkg::DW-1:0] scsi_drive_en_out,
    output logic scsi_parity_drive_en_out,
    // Interrupt request
    output logic irq_out
);

    // ------------------------------------------------------------
    // State and decode
    // ------------------------------------------------------------
    schp_pkg::schp_state_t st_q;
    schp_pkg::schp_state_t st_d;
    schp_pkg::schp_phase_t phase;
    logic [schp_pkg::DW-1:0] ctrl;
    logic [schp_pkg::IDW-1:0] own_id;
    logic [schp_pkg::DW-1:0] id_mask;
    logic [schp_pkg::DW-1:0] rd_val;
    logic [schp_pkg::DW-1:0] set_bits;
    logic [schp_pkg::DW-1:0] clr_bits;
    logic [schp_pkg::DW-1:0] out_byte;
    logic sel;
    logic prog;
    logic wr_edge;
    logic rd_edge;
    logic is_thru;

    // Phase field decoded into the phase type
    always_comb begin
        ctrl = st_q.regs[schp_pkg::REG_CTRL];
        case (ctrl[schp_pkg::CTRL_PH_LSB +: schp_pkg::PHW])
            schp_pkg::PH_ARB: phase = schp_pkg::SCHP_ARB;
            schp_pkg::PH_SEL: phase = schp_pkg::SCHP_SEL;
            schp_pkg::PH_OUT: phase = schp_pkg::SCHP_OUT;
            schp_pkg::PH_IN: phase = schp_pkg::SCHP_IN;
            default: phase = schp_pkg::SCHP_FREE;
        endcase
    end

    // Host qualifiers; every host pin is ignored without select
    assign sel = ~cs_n_in;
    assign is_thru = (reg_addr_in == schp_pkg::ADDR_THRU);
    assign prog = ctrl[schp_pkg::CTRL_PROG];
    assign own_id = ctrl[schp_pkg::CTRL_ID_LSB +: schp_pkg::IDW];
    assign id_mask = schp_pkg::DW'(1) << own_id;
    assign out_byte = st_q.regs[schp_pkg::REG_SCSI_OUT];
    // Trailing edges: strobe was low last cycle, high now
    assign wr_edge = sel & ~st_q.wr_n & write_strobe_n_in;
    assign rd_edge = sel & ~st_q.rd_n & read_strobe_n_in;

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    // Status reads its own sticky flops, not regs; input latch reads from regs
    always_comb begin
        case (reg_addr_in)
            schp_pkg::REG_IRQ_STAT: rd_val = st_q.stat;
            schp_pkg::ADDR_THRU: rd_val = schp_pkg::ZERO;
            default: rd_val = st_q.regs[reg_addr_in];
        endcase
    end

    // ------------------------------------------------------------
    // Interrupt event set and clear masks
    // ------------------------------------------------------------
    always_comb begin
        set_bits = schp_pkg::ZERO;
        clr_bits = schp_pkg::ZERO;
        set_bits[schp_pkg::IRQ_SRST] = scsi_reset_in;
        // Inbound byte checked only when enabled
        set_bits[schp_pkg::IRQ_SPAR] = ctrl[schp_pkg::CTRL_PCHK]
            & (phase == schp_pkg::SCHP_IN)
            & ~(^{scsi_data_in, scsi_parity_in});
        set_bits[schp_pkg::IRQ_WRDY] = prog & wr_edge
            & (reg_addr_in == schp_pkg::REG_SCSI_OUT);
        set_bits[schp_pkg::IRQ_RDONE] = prog & rd_edge
            & (reg_addr_in == schp_pkg::REG_SCSI_IN);
        set_bits[schp_pkg::IRQ_HPAR] = wr_edge
            & (host_parity_in != schp_pkg::odd_par(host_data_in));
        if (wr_edge && reg_addr_in == schp_pkg::REG_IRQ_STAT) begin
            clr_bits = host_data_in;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.rd_n = sel ? read_strobe_n_in : 1'b1;
        st_d.wr_n = sel ? write_strobe_n_in : 1'b1;

        // Register write at strobe release; address F stores nothing
        if (wr_edge && !is_thru) begin
            if (reg_addr_in != schp_pkg::REG_IRQ_STAT
                && reg_addr_in != schp_pkg::REG_SCSI_IN) begin
                st_d.regs[reg_addr_in] = host_data_in;
            end
        end

        // Set wins over a clear in the same cycle
        st_d.stat = (st_q.stat & ~clr_bits) | set_bits;

        // Inbound byte latched for the host while the phase lasts
        if (phase == schp_pkg::SCHP_IN) begin
            st_d.regs[schp_pkg::REG_SCSI_IN] = scsi_data_in;
        end

        // Masked sources gate out; SCSI reset always passes
        st_d.irq = |(st_q.stat & st_q.regs[schp_pkg::REG_IRQ_MASK])
            | st_q.stat[schp_pkg::IRQ_SRST];

        // Host bus driven only under select and read gate
        st_d.host.oe_n = ~(sel & ~read_gate_n_in);
        st_d.host.val.data = rd_val;
        st_d.host.val.par = schp_pkg::odd_par(rd_val);
        if (st_d.host.oe_n) begin
            st_d.host.val = '0;
        end

        // Write-through copies the host byte straight to DMA
        st_d.dma.oe_n = ~(sel & ~write_through_gate_n_in
            & is_thru & dma_dir_in);
        st_d.dma.val.data = host_data_in;
        st_d.dma.val.par = host_parity_in;
        if (st_d.dma.oe_n) begin
            st_d.dma.val = '0;
        end

        // SCSI drive pattern per phase; parity follows data
        case (phase)
            schp_pkg::SCHP_ARB: begin
                st_d.sdo.data = id_mask;
                st_d.sdo.par = 1'b0;
                st_d.sde.data = id_mask;
                st_d.sde.par = 1'b0;
            end
            schp_pkg::SCHP_SEL, schp_pkg::SCHP_OUT: begin
                st_d.sdo.data = out_byte;
                st_d.sdo.par = schp_pkg::odd_par(out_byte);
                st_d.sde.data = '1;
                st_d.sde.par = 1'b1;
            end
            default: begin
                st_d.sdo = '0;
                st_d.sde = '0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register; reset acts without waiting for a clock
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q <= '0;
            st_q.rd_n <= 1'b1;
            st_q.wr_n <= 1'b1;
            st_q.host.oe_n <= 1'b1;
            st_q.dma.oe_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs straight from the state flops
    // ------------------------------------------------------------
    assign host_data_out = st_q.host.val.data;
    assign host_parity_out = st_q.host.val.par;
    assign host_data_oe_n_out = st_q.host.oe_n;
    assign dma_data_out = st_q.dma.val.data;
    assign dma_parity_out = st_q.dma.val.par;
    assign dma_data_oe_n_out = st_q.dma.oe_n;
    assign scsi_data_out = st_q.sdo.data;
    assign scsi_parity_out = st_q.sdo.par;
    assign scsi_drive_en_out = st_q.sde.data;
    assign scsi_parity_drive_en_out = st_q.sde.par;
    assign irq_out = st_q.irq;

endmodule : schp_host_port

`default_nettype wire

// >>> tb/schp_scsi_far.sv
// Far-side SCSI bus model feeding the device inputs
`timescale 1ns/100ps
`default_nettype none
module schp_scsi_far (
    // Clock and fault control
    input wire logic sys_clk_in,
    input wire logic bad_par_in,
    // SCSI bus as seen by the device
    output logic [7:0] scsi_data_in,
    output logic scsi_parity_in
);
    logic [7:0] nxt;
    // Fresh byte every cycle so a stale value never passes for a new one
    always @(negedge sys_clk_in) begin
        nxt = scsi_data_in * 8'h05 + 8'h3B;
        scsi_data_in <= nxt;
        scsi_parity_in <= ~^nxt ^ bad_par_in;
    end
    initial scsi_data_in = 8'h00;
    initial scsi_parity_in = 1'b1;
endmodule : schp_scsi_far
`default_nettype wire

// >>> tb/schp_host_port_chk.sv
// Concurrent checks on the host port outputs
`timescale 1ns/100ps
`default_nettype none
module schp_host_port_chk (
    // Clock, reset and host port
    input wire logic sys_clk_in, sys_rst_in, cs_n_in, read_gate_n_in,
    input wire logic write_through_gate_n_in, host_parity_in, dma_dir_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] host_data_in, host_data_out, dma_data_out,
    input wire logic host_parity_out, host_data_oe_n_out, dma_parity_out,
    input wire logic dma_data_oe_n_out, scsi_reset_in, irq_out,
    // SCSI drive
    input wire logic [7:0] scsi_data_out, scsi_drive_en_out,
    input wire logic scsi_parity_out, scsi_parity_drive_en_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    // Qualifiers of a write-through and of a read
    sequence s_thru;
        !cs_n_in && !write_through_gate_n_in && &reg_addr_in && dma_dir_in;
    endsequence
    sequence s_read;
        !cs_n_in && !read_gate_n_in;
    endsequence
    chk_read_drive: assert property (s_read |=> !host_data_oe_n_out)
        else $error("host bus not driven on read");
    chk_bus_float: assert property ((cs_n_in || read_gate_n_in) |=>
        host_data_oe_n_out && host_data_out == 8'h00) else $error("host bus not released");
    chk_read_parity: assert property (!host_data_oe_n_out |->
        ^{host_data_out, host_parity_out}) else $error("read parity not odd");
    chk_thru_copy: assert property (s_thru |=> !dma_data_oe_n_out &&
        dma_data_out == $past(host_data_in) && dma_parity_out == $past(host_parity_in))
        else $error("write-through byte wrong");
    chk_thru_off: assert property ((cs_n_in || write_through_gate_n_in ||
        !(&reg_addr_in) || !dma_dir_in) |=> dma_data_oe_n_out) else $error("dma bus driven");
    chk_drive_all: assert property (scsi_parity_drive_en_out |->
        scsi_parity_out == ~^scsi_data_out && &scsi_drive_en_out) else $error("drive wrong");
    chk_drive_id: assert property (!scsi_parity_drive_en_out |->
        scsi_data_out == scsi_drive_en_out && $countones(scsi_drive_en_out) <= 1
        && !scsi_parity_out) else $error("idle or arbitration drive wrong");
    chk_srst_irq: assert property (scsi_reset_in |-> ##2 irq_out)
        else $error("bus reset interrupt missing");
    chk_irq_hold: assert property ($fell(irq_out) |-> !$past(cs_n_in, 2) &&
        $past(reg_addr_in, 2) inside {4'h1, 4'h2}) else $error("interrupt dropped");
    chk_reset_clear: assert property (disable iff (1'b0) sys_rst_in |->
        host_data_oe_n_out && dma_data_oe_n_out && !irq_out && scsi_drive_en_out == 8'h00)
        else $error("reset did not clear outputs");
endmodule : schp_host_port_chk
bind schp_host_port schp_host_port_chk u_chk (.*);
`default_nettype wire

// >>> tb/schp_host_port_tb_top.sv
// Self-checking testbench of the host port
`timescale 1ns/100ps
`default_nettype none
module schp_host_port_tb_top;
    logic sys_clk_in = 1'b0, sys_rst_in = 1'b0, cs_n_in = 1'b1, read_strobe_n_in = 1'b1;
    logic read_gate_n_in = 1'b1, write_strobe_n_in = 1'b1, write_through_gate_n_in = 1'b1;
    logic host_parity_in = 1'b1, dma_dir_in = 1'b0, scsi_reset_in = 1'b0, bad_par_in = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] host_data_in = 8'h00, host_data_out, dma_data_out, scsi_data_in;
    logic [7:0] scsi_data_out, scsi_drive_en_out, mem [15];
    logic host_parity_out, host_data_oe_n_out, dma_parity_out, dma_data_oe_n_out;
    logic scsi_parity_in, scsi_parity_out, scsi_parity_drive_en_out, irq_out;
    logic [9:0] e;
    logic [7:0] inb;
    logic [31:0] seed = 32'h0000D3E7;
    int errors = 0, comparisons = 0, cyc = 0;
    schp_host_port uut (.*);
    schp_scsi_far far (.*);
    // 40 MHz clock
    always #12.5 sys_clk_in = ~sys_clk_in;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    // Expected SCSI drive {data, parity, enables, parity enable}
    function automatic logic [17:0] drv(input logic [2:0] ph, id, input logic [7:0] d);
        logic [7:0] b;
        b = 8'h01 << id;
        case (ph)
            schp_pkg::PH_ARB: return {b, 1'b0, b, 1'b0};
            schp_pkg::PH_SEL, schp_pkg::PH_OUT: return {d, ~^d, 8'hFF, 1'b1};
            default: return 18'h00000;
        endcase
    endfunction : drv
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : idle
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic bad);
        @(negedge sys_clk_in);
        cs_n_in = 1'b0;
        reg_addr_in = a;
        host_data_in = d;
        host_parity_in = ~^d ^ bad;
        write_strobe_n_in = 1'b0;
        @(negedge sys_clk_in);
        write_strobe_n_in = 1'b1;
        @(negedge sys_clk_in);
        cs_n_in = 1'b1;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] x, input logic ck);
        @(negedge sys_clk_in);
        cs_n_in = 1'b0;
        reg_addr_in = a;
        read_gate_n_in = 1'b0;
        read_strobe_n_in = 1'b0;
        @(negedge sys_clk_in);
        if (ck) check({host_data_oe_n_out, host_data_out, host_parity_out}, {1'b0, x, ~^x});
        read_gate_n_in = 1'b1;
        read_strobe_n_in = 1'b1;
        @(negedge sys_clk_in);
        cs_n_in = 1'b1;
        check({host_data_oe_n_out, host_data_out}, 9'h100);
    endtask : rd
    task automatic complete_run();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    // Bus byte as the device samples it, to predict the inbound latch
    always @(posedge sys_clk_in) inb <= scsi_data_in;
    // Hang guard, far above the roughly 300 cycles the run needs
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 8000) begin
            errors++;
            complete_run();
        end
    end
    // Main sequence; reset rises after time zero so the flops see its edge
    initial begin
        #1;
        sys_rst_in = 1'b1;
        idle(2);
        sys_rst_in = 1'b0;
        for (int i = 5; i < 15; i++) begin
            seed = xs(seed);
            mem[i] = seed[7:0];
            wr(i[3:0], mem[i], 1'b0);
        end
        for (int i = 5; i < 15; i++) rd(i[3:0], mem[i], 1'b1);
        wr(4'hF, 8'hA5, 1'b0);
        rd(4'hF, 8'h00, 1'b1);
        // Strobe without select must be ignored
        reg_addr_in = 4'h5;
        host_data_in = ~mem[5];
        write_strobe_n_in = 1'b0;
        idle(1);
        write_strobe_n_in = 1'b1;
        rd(4'h5, mem[5], 1'b1);
        // Random write-through traffic
        for (int i = 0; i < 40; i++) begin
            @(negedge sys_clk_in);
            if (i > 0) check({dma_data_oe_n_out, dma_data_out, dma_parity_out}, e);
            seed = xs(seed);
            cs_n_in = &seed[9:8];
            write_through_gate_n_in = &seed[11:10];
            reg_addr_in = seed[12] ? 4'hF : seed[3:0];
            dma_dir_in = |seed[14:13];
            host_data_in = seed[22:15];
            host_parity_in = ~^seed[22:15];
            e = (!cs_n_in && !write_through_gate_n_in && &reg_addr_in && dma_dir_in) ?
                {1'b0, host_data_in, host_parity_in} : 10'h200;
        end
        @(negedge sys_clk_in);
        check({dma_data_oe_n_out, dma_data_out, dma_parity_out}, e);
        cs_n_in = 1'b1;
        write_through_gate_n_in = 1'b1;
        // Every phase code with random own ID
        wr(schp_pkg::REG_SCSI_OUT, 8'h96, 1'b0);
        for (int p = 0; p < 16; p++) begin
            seed = xs(seed);
            wr(schp_pkg::REG_CTRL, {1'b0, p[2:0], 1'b0, seed[2:0]}, 1'b0);
            idle(2);
            check({scsi_data_out, scsi_parity_out, scsi_drive_en_out, scsi_parity_drive_en_out},
                drv(p[2:0], seed[2:0], 8'h96));
        end
        // Interrupts: unmaskable bus reset, then masked host parity error
        wr(schp_pkg::REG_CTRL, 8'h00, 1'b0);
        wr(schp_pkg::REG_IRQ_MASK, 8'h00, 1'b0);
        wr(schp_pkg::REG_IRQ_STAT, 8'hFF, 1'b0);
        scsi_reset_in = 1'b1;
        idle(2);
        scsi_reset_in = 1'b0;
        idle(3);
        check(irq_out, 1'b1);
        rd(schp_pkg::REG_IRQ_STAT, 8'h01, 1'b1);
        wr(schp_pkg::REG_IRQ_STAT, 8'h01, 1'b0);
        idle(3);
        check(irq_out, 1'b0);
        wr(4'h5, 8'h3C, 1'b1);
        idle(3);
        check(irq_out, 1'b0);
        rd(4'h5, 8'h3C, 1'b1);
        rd(schp_pkg::REG_IRQ_STAT, 8'h10, 1'b1);
        wr(schp_pkg::REG_IRQ_MASK, 8'h10, 1'b0);
        idle(3);
        check(irq_out, 1'b1);
        wr(schp_pkg::REG_IRQ_STAT, 8'h10, 1'b0);
        idle(3);
        check(irq_out, 1'b0);
        // Inbound bytes with bad parity, check off then on
        bad_par_in = 1'b1;
        wr(schp_pkg::REG_CTRL, 8'h40, 1'b0);
        rd(schp_pkg::REG_IRQ_STAT, 8'h00, 1'b1);
        wr(schp_pkg::REG_CTRL, 8'h48, 1'b0);
        rd(schp_pkg::REG_IRQ_STAT, 8'h02, 1'b1);
        bad_par_in = 1'b0;
        wr(schp_pkg::REG_IRQ_STAT, 8'hFF, 1'b0);
        // Program transfer in selection phase, then reset in mid-run
        wr(schp_pkg::REG_CTRL, 8'hA0, 1'b0);
        // Last inbound byte stays latched once the phase has moved on
        mem[0] = inb;
        wr(schp_pkg::REG_SCSI_OUT, 8'h5A, 1'b0);
        rd(schp_pkg::REG_SCSI_IN, mem[0], 1'b1);
        rd(schp_pkg::REG_IRQ_STAT, 8'h0C, 1'b1);
        wr(schp_pkg::REG_IRQ_MASK, 8'hFF, 1'b0);
        idle(3);
        sys_rst_in = 1'b1;
        #1;
        check({host_data_oe_n_out, irq_out, scsi_drive_en_out}, 10'h200);
        idle(2);
        sys_rst_in = 1'b0;
        rd(4'h5, 8'h00, 1'b1);
        complete_run();
    end
endmodule : schp_host_port_tb_top
`default_nettype wire
